// ---- rtl/sysctl_pkg.sv ----
// shared constants and carriers for the system control block
package sysctl_pkg;
    // register indices on the cpu and debug buses
    localparam logic [1:0] IDX_PIN_CTRL = 2'h0;
    localparam logic [1:0] IDX_RST_CAUSE = 2'h1;
    localparam logic [1:0] IDX_DBG_FRST = 2'h2;
    // ext_int_pin_control fields
    localparam int PDD_BIT = 6;
    localparam int PE_BIT = 4;
    localparam int FLAG_BIT = 3;
    localparam int ACK_BIT = 2;
    localparam int IE_BIT = 1;
    localparam int MOD_BIT = 0;
    // reset_cause_status fields
    localparam int C_POR_BIT = 7;
    localparam int C_PIN_BIT = 6;
    localparam int C_WDOG_BIT = 5;
    localparam int C_ILLOP_BIT = 4;
    localparam int C_ILLAD_BIT = 3;
    localparam int C_LOWV_BIT = 1;
    // debug_forced_reset field
    localparam int DFR_BIT = 0;
    // values after reset
    localparam logic [7:0] PIN_CTRL_RST = 8'h00;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h82;
    localparam logic [7:0] CAUSE_CLEAR = 8'h00;
    localparam logic [7:0] DBG_READ_VAL = 8'h00;
    // cycles the system reset output is held
    localparam int RESET_HOLD_CYC = 16;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [1:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic watchdog_timeout;
        logic watchdog_enable_option;
        logic unimpl_opcode;
        logic stop_instr;
        logic stop_mode_allow;
        logic background_halt_instr;
        logic background_mode_allow;
        logic illegal_address;
        logic low_volt_trip;
        logic low_voltage_reset_enable;
    } rst_src_s;
endpackage : sysctl_pkg

// ---- rtl/pin_event_detect.sv ----
// external interrupt pin synchroniser, edge and level detector, event flag
`timescale 1ns/100ps
module pin_event_detect (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic pin_in,
    input wire logic enable,
    input wire logic mode,
    input wire logic ack,
    input wire logic clr,
    output logic flag,
    output logic pin_low
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic fall;
    logic set;
    logic ack_ok;

    // pin idles high, so the chain resets high to avoid a false edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign pin_low = ~sync2_r;
    assign fall = prev_r & ~sync2_r;
    assign set = enable & (fall | (mode & ~sync2_r)); // RL7 RL23
    assign ack_ok = ack & ~(mode & ~sync2_r); // RL5

    // a new event beats an acknowledge in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else if (clr) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1; // RL3
        end else if (ack_ok) begin
            flag <= 1'b0; // RL4
        end
    end
endmodule : pin_event_detect

// ---- rtl/reset_cause_capture.sv ----
// reset source qualification and next reset cause vector
`timescale 1ns/100ps
module reset_cause_capture (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ext_reset_pin_n,
    input sysctl_pkg::rst_src_s src,
    input wire logic por_prev,
    output logic trigger,
    output logic low_volt_rst,
    output logic ext_pin_low,
    output logic [7:0] cause_nxt
);
    logic sync1_r;
    logic sync2_r;
    logic illegal_op;
    logic wdog_rst;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= ext_reset_pin_n;
            sync2_r <= sync1_r;
        end
    end

    assign ext_pin_low = ~sync2_r; // RL15
    assign illegal_op = src.unimpl_opcode
        | (src.stop_instr & ~src.stop_mode_allow)
        | (src.background_halt_instr & ~src.background_mode_allow); // RL17
    assign wdog_rst = src.watchdog_timeout & src.watchdog_enable_option; // RL16
    assign low_volt_rst = src.low_volt_trip & src.low_voltage_reset_enable; // RL13
    assign trigger = ext_pin_low | wdog_rst | illegal_op | src.illegal_address
        | low_volt_rst; // RL18

    always_comb begin
        cause_nxt = 8'h00;
        if (low_volt_rst) begin
            cause_nxt[sysctl_pkg::C_POR_BIT] = por_prev; // RL13
            cause_nxt[sysctl_pkg::C_LOWV_BIT] = 1'b1;
        end else begin
            cause_nxt[sysctl_pkg::C_PIN_BIT] = ext_pin_low; // RL14
            cause_nxt[sysctl_pkg::C_WDOG_BIT] = wdog_rst;
            cause_nxt[sysctl_pkg::C_ILLOP_BIT] = illegal_op;
            cause_nxt[sysctl_pkg::C_ILLAD_BIT] = src.illegal_address;
        end
    end
endmodule : reset_cause_capture

// ---- rtl/sys_ctl_top.sv ----
// system control: interrupt pin, reset cause status, debug forced reset
`timescale 1ns/100ps
// What this block does
// RL1 - pull-up off when bit 6 set, pin enabled
// RL2 - bit 4 enables the pin function
// RL3 - bit 3 read-only event flag
// RL4 - writing 1 to bit 2 clears flag
// RL5 - level mode: no clear while pin low
// RL6 - bit 1 gates the interrupt request
// RL7 - bit 0 picks edge or edge-and-level
// RL8 - software writes zero into bit 5
// RL9 - cause flags in bits 7,6,5,4,3,1
// RL10 - cause write restarts watchdog, keeps flags
// RL11 - debug forced reset clears all causes
// RL12 - power-on sets power-on and low-voltage
// RL13 - low-voltage reset keeps power-on flag
// RL14 - other resets record sources active then
// RL15 - low external pin sets pin flag
// RL16 - watchdog reset only when option enabled
// RL17 - illegal, disabled stop or halt opcode
// RL18 - unimplemented address access forces reset
// RL19 - user writes to forced reset ignored
// RL20 - forced reset register reads zero
// RL21 - debug write of bit 0 resets
// RL22 - host drives mode pin during forced reset
// RL23 - disabled pin sets no flag, no request
module sys_ctl_top #(
    parameter int HOLD_CYC = sysctl_pkg::RESET_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input sysctl_pkg::bus_req_s cpu_req,
    output logic [7:0] cpu_rdata,
    input sysctl_pkg::bus_req_s dbg_req,
    input wire logic irq_pin_in,
    input wire logic ext_reset_pin_n,
    input wire logic mode_select_pin,
    input sysctl_pkg::rst_src_s rst_src,
    output logic pin_pullup_en,
    output logic irq_request,
    output logic sys_reset_out,
    output logic wdog_restart,
    output logic bdm_entry
);
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01
    } seq_e;

    generate
        if (HOLD_CYC < 2 || HOLD_CYC > 255) begin : g_bad_hold
            $error("HOLD_CYC must lie in 2..255");
        end
    endgenerate

    seq_e state_r;
    seq_e state_nxt;
    logic [7:0] hold_cnt_r;
    logic pdd_r;
    logic pe_r;
    logic ie_r;
    logic mod_r;
    logic [7:0] cause_r;
    logic forced_r;
    logic ms_sync1_r;
    logic ms_sync2_r;
    logic first_r;
    logic pin_flag;
    logic pin_low;
    logic src_trigger;
    logic low_volt_rst;
    logic ext_pin_low;
    logic [7:0] cause_nxt;
    logic running;
    logic cpu_wr;
    logic cpu_rd;
    logic wr_ctrl;
    logic wr_cause;
    logic ack_pulse;
    logic dbg_force;
    logic enter_rst;
    logic hold_done;

    assign running = (state_r == ST_RUN);
    assign cpu_wr = cpu_req.sel & cpu_req.wr;
    assign cpu_rd = cpu_req.sel & ~cpu_req.wr;
    assign wr_ctrl = cpu_wr & running & (cpu_req.addr == sysctl_pkg::IDX_PIN_CTRL);
    assign wr_cause = cpu_wr & running & (cpu_req.addr == sysctl_pkg::IDX_RST_CAUSE);
    assign ack_pulse = wr_ctrl & cpu_req.wdata[sysctl_pkg::ACK_BIT]; // RL4
    // only the debug port reaches the forced reset bit
    assign dbg_force = dbg_req.sel & dbg_req.wr & running
        & (dbg_req.addr == sysctl_pkg::IDX_DBG_FRST)
        & dbg_req.wdata[sysctl_pkg::DFR_BIT]; // RL19 RL21
    assign enter_rst = running & (src_trigger | dbg_force);
    assign hold_done = (hold_cnt_r == 8'(HOLD_CYC - 1));

    pin_event_detect u_detect (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_in(irq_pin_in),
        .enable(pe_r),
        .mode(mod_r),
        .ack(ack_pulse),
        .clr(~running),
        .flag(pin_flag),
        .pin_low(pin_low)
    );

    reset_cause_capture u_cause (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .ext_reset_pin_n(ext_reset_pin_n),
        .src(rst_src),
        .por_prev(cause_r[sysctl_pkg::C_POR_BIT]),
        .trigger(src_trigger),
        .low_volt_rst(low_volt_rst),
        .ext_pin_low(ext_pin_low),
        .cause_nxt(cause_nxt)
    );

    // power-on also walks through the hold so the system sees a full reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (enter_rst) begin
                    state_nxt = ST_HOLD; // RL21
                end
            end
            ST_HOLD: begin
                if (hold_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_cnt_r <= 8'h00;
        end else if (state_r == ST_HOLD && !hold_done) begin
            hold_cnt_r <= hold_cnt_r + 8'h01;
        end else begin
            hold_cnt_r <= 8'h00;
        end
    end

    assign sys_reset_out = (state_r == ST_HOLD);

    // control bits return to reset values during every reset hold
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pdd_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::PDD_BIT];
            pe_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::PE_BIT];
            ie_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::IE_BIT];
            mod_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::MOD_BIT];
        end else if (!running) begin
            pdd_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::PDD_BIT];
            pe_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::PE_BIT];
            ie_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::IE_BIT];
            mod_r <= sysctl_pkg::PIN_CTRL_RST[sysctl_pkg::MOD_BIT];
        end else if (wr_ctrl) begin
            pdd_r <= cpu_req.wdata[sysctl_pkg::PDD_BIT]; // RL1
            pe_r <= cpu_req.wdata[sysctl_pkg::PE_BIT]; // RL2
            ie_r <= cpu_req.wdata[sysctl_pkg::IE_BIT]; // RL6
            mod_r <= cpu_req.wdata[sysctl_pkg::MOD_BIT]; // RL7
        end
    end

    // bit 5 is not stored; software is expected to keep it zero
    assign pin_pullup_en = pe_r & ~pdd_r; // RL1
    assign irq_request = pin_flag & ie_r & pe_r; // RL6 RL23

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cause_r <= sysctl_pkg::CAUSE_POR_VAL; // RL12
        end else if (enter_rst) begin
            if (dbg_force) begin
                cause_r <= sysctl_pkg::CAUSE_CLEAR; // RL11
            end else begin
                cause_r <= cause_nxt; // RL13 RL14
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdog_restart <= 1'b0;
        end else begin
            wdog_restart <= wr_cause; // RL10
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_sync1_r <= 1'b1;
            ms_sync2_r <= 1'b1;
        end else begin
            ms_sync1_r <= mode_select_pin;
            ms_sync2_r <= ms_sync1_r;
        end
    end

    // the mode pin is judged when a forced reset releases
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            forced_r <= 1'b0;
            bdm_entry <= 1'b0;
        end else if (dbg_force) begin
            forced_r <= 1'b1;
        end else if (state_r == ST_HOLD && hold_done) begin
            forced_r <= 1'b0;
            bdm_entry <= forced_r & ~ms_sync2_r; // RL22
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            case (cpu_req.addr)
                sysctl_pkg::IDX_PIN_CTRL: begin
                    cpu_rdata <= {1'b0, pdd_r, 1'b0, pe_r, pin_flag, 1'b0,
                        ie_r, mod_r}; // RL3 RL4
                end
                sysctl_pkg::IDX_RST_CAUSE: begin
                    cpu_rdata <= cause_r; // RL9
                end
                sysctl_pkg::IDX_DBG_FRST: begin
                    cpu_rdata <= sysctl_pkg::DBG_READ_VAL; // RL20
                end
                default: begin
                    cpu_rdata <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_pullup_on_enable: assert property (
        wr_ctrl && cpu_req.wdata[sysctl_pkg::PE_BIT] && !cpu_req.wdata[sysctl_pkg::PDD_BIT]
        |=> pin_pullup_en) // RL1
        else $error("pull-up not active after enable");
    a_pullup_off_disable: assert property (
        wr_ctrl && cpu_req.wdata[sysctl_pkg::PDD_BIT] |=> !pin_pullup_en) // RL1
        else $error("pull-up not released");
    a_enable_stored: assert property (
        wr_ctrl |=> pe_r == $past(cpu_req.wdata[sysctl_pkg::PE_BIT])) // RL2
        else $error("pin enable not stored");
    a_flag_readback: assert property (
        cpu_rd && cpu_req.addr == sysctl_pkg::IDX_PIN_CTRL
        |=> cpu_rdata[sysctl_pkg::FLAG_BIT] == $past(pin_flag)
        && !cpu_rdata[sysctl_pkg::ACK_BIT]) // RL3
        else $error("flag readback wrong");
    a_ack_clears_flag: assert property (
        ack_pulse && !pin_low && pin_flag |=> !pin_flag) // RL4
        else $error("acknowledge did not clear flag");
    a_level_blocks_ack: assert property (
        ack_pulse && mod_r && pe_r && pin_low |=> pin_flag) // RL5
        else $error("flag cleared while pin low in level mode");
    a_irq_gated: assert property (
        pin_flag && !ie_r |-> !irq_request) // RL6
        else $error("request raised with gate off");
    a_irq_raised: assert property (
        running && pe_r && ie_r && pin_low && $past(!pin_low) && !wr_ctrl
        |=> irq_request) // RL6
        else $error("edge raised no request");
    a_edge_only: assert property (
        pe_r && !mod_r && pin_low && $past(pin_low) && !pin_flag |=> !pin_flag) // RL7
        else $error("steady low set flag in edge mode");
    a_disabled_quiet: assert property (
        $rose(pin_flag) |-> $past(pe_r)) // RL23
        else $error("flag set while pin function off");
    a_cause_read: assert property (
        cpu_rd && cpu_req.addr == sysctl_pkg::IDX_RST_CAUSE
        |=> cpu_rdata == $past(cause_r) && !cpu_rdata[2] && !cpu_rdata[0]) // RL9
        else $error("cause read wrong");
    a_restart_keeps: assert property (
        wr_cause && !enter_rst |=> wdog_restart && $stable(cause_r)) // RL10
        else $error("cause write misbehaved");
    a_forced_clear: assert property (
        dbg_force |=> cause_r == sysctl_pkg::CAUSE_CLEAR && sys_reset_out) // RL11
        else $error("forced reset did not clear causes");
    a_forced_hold: assert property (
        dbg_force |=> sys_reset_out [*2]) // RL21
        else $error("forced reset too short");
    a_por_value: assert property (
        first_r |-> cause_r == sysctl_pkg::CAUSE_POR_VAL && sys_reset_out) // RL12
        else $error("power-on cause wrong");
    a_lowv_entry: assert property (
        running && low_volt_rst && !dbg_force
        |=> cause_r[sysctl_pkg::C_LOWV_BIT]
        && cause_r[sysctl_pkg::C_POR_BIT] == $past(cause_r[sysctl_pkg::C_POR_BIT])
        && !cause_r[sysctl_pkg::C_PIN_BIT]) // RL13
        else $error("low-voltage cause wrong");
    a_other_entry: assert property (
        running && src_trigger && !low_volt_rst && !dbg_force
        |=> !cause_r[sysctl_pkg::C_POR_BIT] && !cause_r[sysctl_pkg::C_LOWV_BIT]
        && cause_r[sysctl_pkg::C_ILLAD_BIT] == $past(rst_src.illegal_address)) // RL14 RL18
        else $error("other reset cause wrong");
    a_pin_cause: assert property (
        running && ext_pin_low && !low_volt_rst && !dbg_force
        |=> cause_r[sysctl_pkg::C_PIN_BIT]) // RL15
        else $error("pin cause missing");
    a_wdog_needs_en: assert property (
        $rose(sys_reset_out) && cause_r[sysctl_pkg::C_WDOG_BIT]
        |-> $past(rst_src.watchdog_enable_option)) // RL16
        else $error("watchdog reset while blocked");
    a_stop_illegal: assert property (
        running && rst_src.stop_instr && !rst_src.stop_mode_allow
        && !low_volt_rst && !dbg_force |=> cause_r[sysctl_pkg::C_ILLOP_BIT]) // RL17
        else $error("disabled stop not illegal");
    a_user_write_ignored: assert property (
        cpu_wr && running && cpu_req.addr == sysctl_pkg::IDX_DBG_FRST
        && !src_trigger && !dbg_force |=> !sys_reset_out) // RL19
        else $error("user write forced reset");
    a_dbg_reads_zero: assert property (
        cpu_rd && cpu_req.addr == sysctl_pkg::IDX_DBG_FRST |=> cpu_rdata == 8'h00) // RL20
        else $error("forced reset register read nonzero");

    c_forced_reset: cover property (dbg_force ##1 sys_reset_out);
    c_irq_raised: cover property (running && irq_request);
    c_lowv_reset: cover property (running && low_volt_rst);
    c_ack_clear: cover property (ack_pulse && pin_flag ##1 !pin_flag);
endmodule : sys_ctl_top

// ---- verif/pin_host_model.sv ----
// interrupt source on the pin and serial debug host beside the control block
`timescale 1ns/100ps
module pin_host_model (
    input wire logic core_clk,
    input wire logic pin_low,
    input wire logic force_go,
    input wire logic bdm_want,
    output logic irq_pin_in,
    output sysctl_pkg::bus_req_s dbg_req,
    output logic mode_select_pin
);
    logic [7:0] idle_cnt = 8'h00;

    // open drain source; a board pull-up stands in when the internal one is off
    assign irq_pin_in = pin_low ? 1'b0 : 1'b1;
    // host holds the mode line from the forced write to the end of the reset
    assign mode_select_pin = ~bdm_want;

    // one driver only; the first edge lands well inside the reset hold
    always @(posedge core_clk) begin
        idle_cnt <= idle_cnt + 8'h01;
        if (force_go) begin
            dbg_req <= '{sel: 1'b1, wr: 1'b1, addr: sysctl_pkg::IDX_DBG_FRST, wdata: 8'h01};
        end else begin
            // not selected: junk that changes every cycle, so sel must qualify
            dbg_req <= '{sel: 1'b0, wr: 1'b1, addr: idle_cnt[1:0], wdata: idle_cnt};
        end
    end
endmodule : pin_host_model

// ---- verif/test_sys_ctl_top.sv ----
// self-checking bench for the system control block
`timescale 1ns/100ps
module test_sys_ctl_top;
    // short hold keeps the run brief
    localparam int HOLD = 4;
    localparam logic [7:0] HC = 8'(HOLD);
    localparam logic [1:0] PC = sysctl_pkg::IDX_PIN_CTRL;
    localparam logic [1:0] RC = sysctl_pkg::IDX_RST_CAUSE;
    localparam logic [1:0] DF = sysctl_pkg::IDX_DBG_FRST;

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    sysctl_pkg::bus_req_s cpu_req = '0;
    sysctl_pkg::bus_req_s dbg_req;
    sysctl_pkg::rst_src_s rst_src = '0;
    logic [7:0] cpu_rdata;
    logic irq_pin_in, mode_select_pin, pin_pullup_en, irq_request;
    logic sys_reset_out, wdog_restart, bdm_entry;
    logic ext_reset_pin_n = 1'b1;
    logic pin_low = 1'b0;
    logic force_go = 1'b0;
    logic bdm_want = 1'b0;
    int num_errors = 0;
    int total_checks = 0;

    sys_ctl_top #(.HOLD_CYC(HOLD)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .dbg_req(dbg_req), .irq_pin_in(irq_pin_in), .ext_reset_pin_n(ext_reset_pin_n),
        .mode_select_pin(mode_select_pin), .rst_src(rst_src), .pin_pullup_en(pin_pullup_en),
        .irq_request(irq_request), .sys_reset_out(sys_reset_out),
        .wdog_restart(wdog_restart), .bdm_entry(bdm_entry)
    );

    pin_host_model partner (
        .core_clk(core_clk), .pin_low(pin_low), .force_go(force_go), .bdm_want(bdm_want),
        .irq_pin_in(irq_pin_in), .dbg_req(dbg_req), .mode_select_pin(mode_select_pin)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [7:0] act, input logic [7:0] exp);
        total_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cpu_req <= '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        cpu_req <= '0;
        #1;
    endtask : wr

    task rc(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        cpu_req <= '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        cpu_req <= '0;
        #1;
        chk(cpu_rdata, exp);
    endtask : rc

    // moves the pin, then waits past the sync chain
    task pin(input logic lo);
        @(posedge core_clk);
        pin_low <= lo;
        repeat (5) @(posedge core_clk);
        #1;
    endtask : pin

    // source bits: wdt,wen,unimpl,stop,stop_ok,halt,halt_ok,ill_addr,lv_trip,lv_en
    task trig(input logic [9:0] s, input logic p, input logic f, input logic [7:0] hc,
              input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        @(posedge core_clk);
        rst_src <= sysctl_pkg::rst_src_s'(s);
        ext_reset_pin_n <= ~p;
        force_go <= f;
        for (int i = 0; i < 14; i++) begin
            @(posedge core_clk);
            if (i == 1) begin
                rst_src <= '0;
                ext_reset_pin_n <= 1'b1;
                force_go <= 1'b0;
            end
            #1;
            if (sys_reset_out === 1'b1) n = n + 8'h01;
        end
        chk(n, hc);
        rc(RC, exp);
    endtask : trig

    initial begin
        repeat (4) @(posedge core_clk);
        chk(sys_reset_out, 1'b1);
        chk(cpu_rdata, 8'h00);
        reset_n <= 1'b1;
        repeat (HOLD + 3) @(posedge core_clk);
        #1;
        chk(sys_reset_out, 1'b0);
        rc(RC, 8'h82);
        rc(PC, 8'h00);
        chk(pin_pullup_en, 1'b0);
        rc(2'h3, 8'h00);
        wr(RC, 8'hFF);
        chk(wdog_restart, 1'b1);
        @(posedge core_clk);
        #1;
        chk(wdog_restart, 1'b0);
        rc(RC, 8'h82);
        wr(DF, 8'h01);
        chk(sys_reset_out, 1'b0);
        rc(DF, 8'h00);
        rc(RC, 8'h82);
        trig(10'h003, 1'b0, 1'b0, HC, 8'h82);
        // disabled pin: a falling edge must leave no trace
        pin(1'b1);
        rc(PC, 8'h00);
        chk(irq_request, 1'b0);
        pin(1'b0);
        wr(PC, 8'h12);
        chk(pin_pullup_en, 1'b1);
        rc(PC, 8'h12);
        wr(2'h3, 8'hFF);
        rc(PC, 8'h12);
        wr(PC, 8'h52);
        chk(pin_pullup_en, 1'b0);
        pin(1'b1);
        rc(PC, 8'h5A);
        chk(irq_request, 1'b1);
        wr(PC, 8'h50);
        chk(irq_request, 1'b0);
        rc(PC, 8'h58);
        wr(PC, 8'h56);
        pin(1'b1);
        rc(PC, 8'h52);
        chk(irq_request, 1'b0);
        pin(1'b0);
        wr(PC, 8'h53);
        pin(1'b1);
        chk(irq_request, 1'b1);
        wr(PC, 8'h57);
        rc(PC, 8'h5B);
        pin(1'b0);
        wr(PC, 8'h57);
        rc(PC, 8'h53);
        trig(10'h300, 1'b0, 1'b0, HC, 8'h20);
        rc(PC, 8'h00);
        trig(10'h200, 1'b0, 1'b0, 8'h00, 8'h20);
        trig(10'h080, 1'b0, 1'b0, HC, 8'h10);
        trig(10'h004, 1'b0, 1'b0, HC, 8'h08);
        trig(10'h040, 1'b0, 1'b0, HC, 8'h10);
        trig(10'h060, 1'b0, 1'b0, 8'h00, 8'h10);
        trig(10'h000, 1'b1, 1'b0, HC, 8'h40);
        trig(10'h010, 1'b0, 1'b0, HC, 8'h10);
        trig(10'h018, 1'b0, 1'b0, 8'h00, 8'h10);
        trig(10'h002, 1'b0, 1'b0, 8'h00, 8'h10);
        trig(10'h003, 1'b0, 1'b0, HC, 8'h02);
        trig(10'h304, 1'b0, 1'b0, HC, 8'h28);
        trig(10'h307, 1'b0, 1'b0, HC, 8'h02);
        @(posedge core_clk);
        bdm_want <= 1'b1;
        trig(10'h000, 1'b0, 1'b1, HC, 8'h00);
        chk(bdm_entry, 1'b1);
        @(posedge core_clk);
        bdm_want <= 1'b0;
        trig(10'h000, 1'b0, 1'b1, HC, 8'h00);
        chk(bdm_entry, 1'b0);
        stop_test();
    end
endmodule : test_sys_ctl_top
